// *** hdl/scd_top.sv ***
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "scd_consts.svh"
// Functional notes
// - sample all sixteen test and eight transmit-enable straps when leaving reset
// - strap bit 3 high means unmanaged serial, low means lightly managed serial
// - strap bit 0 turns serial strobe debounce on or off
// - strap bits 6..4 give the serial bus device identifier
// - strap bit 7 low enables eeprom load, unmanaged mode only
// - strap bit 9 enables hot swap; transmit-enable straps give module type
// - with power saving, idle port macs sleep and wake on activity
// - strap bit 12 enables a five second stuck state machine monitor
// - unmanaged mode switches with defaults once table init ends after reset
// - system defaults: port vlan, no zero learn, drops, no ipmc, trunk/mirror off
// - aging 300 seconds, all vlan priorities map to priority 0
// - flow control after 96 frames, wred 0, flood control off, no pools
// - per-port defaults: forwarding, learning, strict priority, no security
// - frames 64 to 1522 bytes, pad short frames, standard preamble
// - access ports rmii, 100 full with flow control, pool 96, threshold 48
// - uplink mii, 100 full with flow control, pool 384, threshold 192
// - managed mode switches only after host sets init-complete bit 4
// - managed defaults: cpu address zero, group forward, irqs on, reports off
// - managed defaults: heartbeat off, cpu port 100 full, pad 8, pool 96/48
// - module-detect strap high enables phy detection for hot swap
// - strap bit 11 high enables mac power saving
// - transmit-enable strap levels readable from the strap status register
module scd_top #(
   parameter logic [14:0] TABLE_INIT_CYCLES = 15'(`SCD_TABLE_INIT_NS / `SCD_CLK_PERIOD_NS),
   parameter logic [30:0] TIMEOUT_CYCLES    = 31'(`SCD_TIMEOUT_S * 64'd1000000000 / `SCD_CLK_PERIOD_NS),
   parameter logic [9:0]  IDLE_CYCLES       = 10'(`SCD_IDLE_CYCLES)
) (
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // strap pins
   input  wire logic [15:0] test_out_strap,
   input  wire logic [7:0]  port_tx_enable_strap,
   // activity and state machine monitor inputs
   input  wire logic [8:0]  port_activity,
   input  wire logic        fsm_busy,
   // decoded options and status
   output logic             managed_mode,
   output logic             debounce_enable,
   output logic [2:0]       device_id,
   output logic             eeprom_load_enable,
   output logic             hot_swap_enable,
   output logic [7:0]       port_module_type,
   output logic             power_save_enable,
   output logic             timeout_monitor_enable,
   output logic             switching_enable,
   output logic [8:0]       port_low_power,
   output logic             timeout_reset_req
);

   scd_pkg::scd_state_regs_type s_q;
   scd_pkg::scd_state_regs_type s_d;

   logic        setup_phase;
   logic        access_done;
   logic        cfg_open;
   logic [31:0] rd_word;
   logic        addr_hit;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & s_q.pready;
   // defaults are only editable by a managing host before it releases switching
   assign cfg_open    = s_q.managed & ~s_q.init_done & s_q.tables_ready;

   // read mux, one word per register
   always_comb begin
      rd_word  = 32'h0000_0000;
      addr_hit = 1'b1;
      case (paddr)
         `SCD_OFS_GLOBAL_CTRL:   rd_word[`SCD_GCR_INIT_DONE] = s_q.init_done;
         `SCD_OFS_STRAP_STATUS:  rd_word[7:0] = s_q.tx_strap;
         `SCD_OFS_STRAP_OPTIONS: rd_word = {15'h0000, s_q.strap_ok, s_q.strap};
         `SCD_OFS_STATE:         rd_word = {26'h000_0000, s_q.switching, s_q.tables_ready,
                                            s_q.managed, s_q.cap_done, s_q.state};
         `SCD_OFS_SYS_CFG:       rd_word = {s_q.fc_trigger, s_q.aging};
         `SCD_OFS_ACCESS_POOL:   rd_word = {`SCD_RST_ACCESS_THR, `SCD_RST_ACCESS_POOL};
         `SCD_OFS_UPLINK_POOL:   rd_word = {`SCD_RST_UPLINK_THR, `SCD_RST_UPLINK_POOL};
         `SCD_OFS_CPU_POOL:      rd_word = {4'(`SCD_RST_CPU_PAD), 12'h000,
                                            8'(`SCD_RST_CPU_THR), 8'(`SCD_RST_CPU_POOL)};
         `SCD_OFS_FRAME_SIZE:    rd_word = {`SCD_RST_FRAME_MAX, `SCD_RST_FRAME_MIN};
         `SCD_OFS_FLAGS:         rd_word = s_q.flags;
         default:                addr_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d = s_q;

      // apb answers one cycle after setup, no wait states
      s_d.pready  = setup_phase;
      s_d.pslverr = setup_phase & ~addr_hit;
      if (setup_phase) begin
         s_d.prdata = pwrite ? 32'h0000_0000 : rd_word;
      end

      // register writes land in the access cycle
      if (access_done && pwrite && addr_hit) begin
         case (paddr)
            `SCD_OFS_GLOBAL_CTRL: begin
               // init-complete only means something to a managing host
               if (s_q.managed && s_q.tables_ready && pwdata[`SCD_GCR_INIT_DONE]) begin
                  s_d.init_done = 1'b1;
               end
            end
            `SCD_OFS_SYS_CFG: begin
               if (cfg_open) begin
                  s_d.aging      = pwdata[15:0];
                  s_d.fc_trigger = pwdata[31:16];
               end
            end
            `SCD_OFS_FLAGS: begin
               if (cfg_open) begin
                  s_d.flags = pwdata;
               end
            end
            default: ;
         endcase
      end

      case (s_q.state)
         scd_pkg::ST_CAPTURE: begin
            // first enabled edge after release latches the pins once
            s_d.cap_done      = 1'b1;
            s_d.strap         = test_out_strap;
            s_d.tx_strap      = port_tx_enable_strap;
            s_d.managed       = ~test_out_strap[`SCD_STRAP_CPU_MODE];
            s_d.debounce_en   = test_out_strap[`SCD_STRAP_DEBOUNCE];
            s_d.device_id     = test_out_strap[`SCD_STRAP_ID_HI:`SCD_STRAP_ID_LO];
            s_d.eeprom_en     = test_out_strap[`SCD_STRAP_CPU_MODE] &
                                ~test_out_strap[`SCD_STRAP_EEPROM_N];
            s_d.hot_swap_en   = test_out_strap[`SCD_STRAP_HOT_SWAP];
            s_d.module_type   = test_out_strap[`SCD_STRAP_HOT_SWAP] ?
                                port_tx_enable_strap : 8'h00;
            s_d.power_save_en = test_out_strap[`SCD_STRAP_POWER_SAVE];
            s_d.timeout_en    = test_out_strap[`SCD_STRAP_TIMEOUT];
            // flag a board that leaves reserved straps at the wrong level
            s_d.strap_ok      = ((test_out_strap & `SCD_STRAP_RSV_HI_MASK) == `SCD_STRAP_RSV_HI_MASK) &&
                                ((test_out_strap & `SCD_STRAP_RSV_LO_MASK) == 16'h0000);
            s_d.init_cnt      = 15'h0000;
            s_d.state         = scd_pkg::ST_INIT_TABLES;
         end
         scd_pkg::ST_INIT_TABLES: begin
            // control tables are cleared here; a host must not write meanwhile
            if (s_q.init_cnt >= TABLE_INIT_CYCLES - 15'h0001) begin
               s_d.tables_ready = 1'b1;
               if (s_q.managed) begin
                  s_d.state = scd_pkg::ST_WAIT_HOST;
               end else begin
                  s_d.switching = 1'b1;
                  s_d.state     = scd_pkg::ST_SWITCHING;
               end
            end else begin
               s_d.init_cnt = s_q.init_cnt + 15'h0001;
            end
         end
         scd_pkg::ST_WAIT_HOST: begin
            if (s_q.init_done) begin
               s_d.switching = 1'b1;
               s_d.state     = scd_pkg::ST_SWITCHING;
            end
         end
         scd_pkg::ST_SWITCHING: ;
         default: s_d.state = scd_pkg::ST_CAPTURE;
      endcase

      // per-port idle counters put macs to sleep; activity wakes at once
      for (int p = 0; p < 9; p++) begin
         if (!s_q.power_save_en || port_activity[p]) begin
            s_d.idle_cnt[p*10 +: 10] = 10'h000;
            s_d.low_power[p]         = 1'b0;
         end else if (s_q.idle_cnt[p*10 +: 10] >= IDLE_CYCLES - 10'h001) begin
            s_d.low_power[p] = 1'b1;
         end else begin
            s_d.idle_cnt[p*10 +: 10] = s_q.idle_cnt[p*10 +: 10] + 10'h001;
         end
      end

      // stuck-machine watchdog; the counter saturates so one stall yields one pulse
      s_d.timeout_req = 1'b0;
      if (!s_q.timeout_en || !fsm_busy) begin
         s_d.busy_cnt = 31'h0000_0000;
      end else if (s_q.busy_cnt < TIMEOUT_CYCLES) begin
         s_d.busy_cnt = s_q.busy_cnt + 31'h0000_0001;
         if (s_q.busy_cnt == TIMEOUT_CYCLES - 31'h0000_0001) begin
            s_d.timeout_req = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; defaults come up with reset, straps are caught later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q            <= '0;
         s_q.state      <= scd_pkg::ST_CAPTURE;
         s_q.aging      <= `SCD_RST_AGING_S;
         s_q.fc_trigger <= `SCD_RST_FC_TRIGGER;
         s_q.flags      <= `SCD_RST_FLAGS;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign prdata                 = s_q.prdata;
   assign pready                 = s_q.pready;
   assign pslverr                = s_q.pslverr;
   assign managed_mode           = s_q.managed;
   assign debounce_enable        = s_q.debounce_en;
   assign device_id              = s_q.device_id;
   assign eeprom_load_enable     = s_q.eeprom_en;
   assign hot_swap_enable        = s_q.hot_swap_en;
   assign port_module_type       = s_q.module_type;
   assign power_save_enable      = s_q.power_save_en;
   assign timeout_monitor_enable = s_q.timeout_en;
   assign switching_enable       = s_q.switching;
   assign port_low_power         = s_q.low_power;
   assign timeout_reset_req      = s_q.timeout_req;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // sampled reset keeps the release edge out: the state register was still in reset there
   property p_capture;
      (presetn && s_q.state == scd_pkg::ST_CAPTURE && clk_en) |=>
         (s_q.strap == $past(test_out_strap) && s_q.tx_strap == $past(port_tx_enable_strap));
   endproperty
   a_capture: assert property (p_capture) else $error("straps not captured");

   property p_hold;
      (s_q.cap_done && $past(s_q.cap_done)) |-> ($stable(s_q.strap) && $stable(s_q.tx_strap));
   endproperty
   a_hold: assert property (p_hold) else $error("captured straps changed");

   property p_mode;
      s_q.cap_done |-> (managed_mode == !s_q.strap[3] && debounce_enable == s_q.strap[0]);
   endproperty
   a_mode: assert property (p_mode) else $error("cpu mode or debounce wrong");

   property p_devid;
      s_q.cap_done |-> device_id == s_q.strap[6:4];
   endproperty
   a_devid: assert property (p_devid) else $error("device id wrong");

   property p_eeprom;
      s_q.cap_done |-> eeprom_load_enable == (s_q.strap[3] && !s_q.strap[7]);
   endproperty
   a_eeprom: assert property (p_eeprom) else $error("eeprom enable wrong");

   property p_module;
      s_q.cap_done |-> port_module_type == (s_q.strap[9] ? s_q.tx_strap : 8'h00);
   endproperty
   a_module: assert property (p_module) else $error("module type wrong");

   property p_managed_gate;
      (switching_enable && managed_mode) |-> s_q.init_done;
   endproperty
   a_managed_gate: assert property (p_managed_gate) else $error("switching before init");

   property p_unmanaged_go;
      (s_q.state == scd_pkg::ST_INIT_TABLES && s_q.tables_ready == 1'b0 && !managed_mode && clk_en &&
       s_q.init_cnt >= TABLE_INIT_CYCLES - 15'h0001) |=> switching_enable;
   endproperty
   a_unmanaged_go: assert property (p_unmanaged_go) else $error("unmanaged start late");

   property p_wake;
      (clk_en && port_activity[0]) |=> !port_low_power[0];
   endproperty
   a_wake: assert property (p_wake) else $error("port did not wake");

   property p_timeout_off;
      !timeout_monitor_enable |-> !timeout_reset_req;
   endproperty
   a_timeout_off: assert property (p_timeout_off) else $error("watchdog fired while off");

   property p_apb_ready;
      (setup_phase && clk_en) |=> pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb answer missing");

   c_unmanaged: cover property (switching_enable && !managed_mode);
   c_managed:   cover property (switching_enable && managed_mode);
   c_sleep:     cover property (port_low_power[0] ##1 !port_low_power[0]);
   c_timeout:   cover property (timeout_reset_req);

endmodule

// *** hdl/scd_consts.svh ***
`ifndef SCD_CONSTS_SVH
`define SCD_CONSTS_SVH
// clock and timing
`define SCD_CLK_PERIOD_NS     4
`define SCD_TABLE_INIT_NS     100000
`define SCD_TIMEOUT_S         5
`define SCD_IDLE_CYCLES       1000
// strap bit positions
`define SCD_STRAP_DEBOUNCE    0
`define SCD_STRAP_CPU_MODE    3
`define SCD_STRAP_ID_LO       4
`define SCD_STRAP_ID_HI       6
`define SCD_STRAP_EEPROM_N    7
`define SCD_STRAP_HOT_SWAP    9
`define SCD_STRAP_POWER_SAVE  11
`define SCD_STRAP_TIMEOUT     12
`define SCD_STRAP_RSV_HI_MASK 16'hE106
`define SCD_STRAP_RSV_LO_MASK 16'h0400
// register byte offsets
`define SCD_OFS_GLOBAL_CTRL   12'h000
`define SCD_OFS_STRAP_STATUS  12'h004
`define SCD_OFS_STRAP_OPTIONS 12'h008
`define SCD_OFS_STATE         12'h00C
`define SCD_OFS_SYS_CFG       12'h010
`define SCD_OFS_ACCESS_POOL   12'h014
`define SCD_OFS_UPLINK_POOL   12'h018
`define SCD_OFS_CPU_POOL      12'h01C
`define SCD_OFS_FRAME_SIZE    12'h020
`define SCD_OFS_FLAGS         12'h024
// field positions
`define SCD_GCR_INIT_DONE     4
// reset values of the default configuration
`define SCD_RST_AGING_S       16'h012C
`define SCD_RST_FC_TRIGGER    16'h0060
`define SCD_RST_ACCESS_POOL   16'h0060
`define SCD_RST_ACCESS_THR    16'h0030
`define SCD_RST_UPLINK_POOL   16'h0180
`define SCD_RST_UPLINK_THR    16'h00C0
`define SCD_RST_CPU_POOL      16'h0060
`define SCD_RST_CPU_THR       16'h0030
`define SCD_RST_CPU_PAD       16'h0008
`define SCD_RST_FRAME_MIN     16'h0040
`define SCD_RST_FRAME_MAX     16'h05F2
`define SCD_RST_FLAGS         32'h0020_BF45
`endif

// *** hdl/scd_pkg.sv ***
package scd_pkg;
   typedef enum logic [1:0] {
      ST_CAPTURE,
      ST_INIT_TABLES,
      ST_WAIT_HOST,
      ST_SWITCHING
   } scd_state_type;

   typedef struct packed {
      scd_state_type state;
      logic          cap_done;
      logic [15:0]   strap;
      logic [7:0]    tx_strap;
      logic [14:0]   init_cnt;
      logic          tables_ready;
      logic          init_done;
      logic [15:0]   aging;
      logic [15:0]   fc_trigger;
      logic [31:0]   flags;
      logic          managed;
      logic          debounce_en;
      logic [2:0]    device_id;
      logic          eeprom_en;
      logic          hot_swap_en;
      logic [7:0]    module_type;
      logic          power_save_en;
      logic          timeout_en;
      logic          strap_ok;
      logic          switching;
      logic [8:0]    low_power;
      logic [89:0]   idle_cnt;
      logic [30:0]   busy_cnt;
      logic          timeout_req;
      logic [31:0]   prdata;
      logic          pready;
      logic          pslverr;
   } scd_state_regs_type;
endpackage

// *** verification/scd_strap_board.sv ***
`timescale 1ns/1ps
module scd_strap_board (
   // board set-up chosen by the bench
   input  wire logic [15:0] strap_cfg,
   input  wire logic [7:0]  tx_cfg,
   input  wire logic        wiggle,
   // strap pins seen by the switch
   output logic      [15:0] test_out_strap,
   output logic      [7:0]  port_tx_enable_strap
);
   ////////////////////////////////////////////////////////////////////////////
   // resistors hold reserved straps at their fixed levels
   // wiggle stands for the pins toggling after capture, when the transmit
   // enables turn into live outputs and the test pins carry other traffic
   assign test_out_strap       = wiggle ? ~strap_cfg : ((strap_cfg | 16'hE106) & ~16'h0400);
   assign port_tx_enable_strap = wiggle ? ~tx_cfg : tx_cfg;
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   localparam int TIC = 8;
   localparam int TOC = 20;
   localparam int IDC = 5;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        clk_en  = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [15:0] strap_cfg = 16'hFB5F;
   logic [7:0]  tx_cfg    = 8'hA5;
   logic        wiggle    = 1'b0;
   logic [8:0]  port_activity = 9'h1FF;
   logic        fsm_busy      = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic [15:0] test_out_strap;
   logic [7:0]  port_tx_enable_strap, port_module_type;
   logic        managed_mode, debounce_enable, eeprom_load_enable, hot_swap_enable;
   logic        power_save_enable, timeout_monitor_enable, switching_enable, timeout_reset_req;
   logic [2:0]  device_id;
   logic [8:0]  port_low_power;
   int          miscompares = 0;
   int          tests_run   = 0;
   int          cycles      = 0;

   ////////////////////////////////////////////////////////////////////////////
   // short counts so that the run stays brief
   scd_top #(.TABLE_INIT_CYCLES(15'(TIC)), .TIMEOUT_CYCLES(31'(TOC)), .IDLE_CYCLES(10'(IDC))) i_dut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .test_out_strap(test_out_strap), .port_tx_enable_strap(port_tx_enable_strap),
      .port_activity(port_activity), .fsm_busy(fsm_busy), .managed_mode(managed_mode),
      .debounce_enable(debounce_enable), .device_id(device_id), .eeprom_load_enable(eeprom_load_enable),
      .hot_swap_enable(hot_swap_enable), .port_module_type(port_module_type),
      .power_save_enable(power_save_enable), .timeout_monitor_enable(timeout_monitor_enable),
      .switching_enable(switching_enable), .port_low_power(port_low_power),
      .timeout_reset_req(timeout_reset_req));
   scd_strap_board i_board (.strap_cfg(strap_cfg), .tx_cfg(tx_cfg), .wiggle(wiggle),
      .test_out_strap(test_out_strap), .port_tx_enable_strap(port_tx_enable_strap));

   ////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #2 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles >= 5000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // one apb transfer; waits as long as the slave takes, only the hang guard ends it
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      e  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, d, e);
      check(nm, exp, d);
      check("read error", 32'h0000_0000, {31'h0, e});
   endtask

   task automatic do_reset(input logic [15:0] s, input logic [7:0] t);
      @(posedge pclk);
      presetn   <= 1'b0;
      wiggle    <= 1'b0;
      strap_cfg <= s;
      tx_cfg    <= t;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   // decoded options follow the straps bit by bit
   task automatic check_opts(input logic [15:0] s, input logic [7:0] t);
      check("managed", {31'h0, !s[3]}, {31'h0, managed_mode});
      check("debounce", {31'h0, s[0]}, {31'h0, debounce_enable});
      check("device id", {29'h0, s[6:4]}, {29'h0, device_id});
      check("eeprom", {31'h0, s[3] & ~s[7]}, {31'h0, eeprom_load_enable});
      check("hot swap", {31'h0, s[9]}, {31'h0, hot_swap_enable});
      check("module type", {24'h0, s[9] ? t : 8'h00}, {24'h0, port_module_type});
      check("power save", {31'h0, s[11]}, {31'h0, power_save_enable});
      check("timeout enable", {31'h0, s[12]}, {31'h0, timeout_monitor_enable});
      rd_chk("strap status", 12'h004, {24'h0, t});
      rd_chk("strap options", 12'h008, {15'h0, 1'b1, s});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // unmanaged start-up: defaults, delay to switching, refusals, held straps
   task automatic sc_unmanaged();
      int          n;
      logic [31:0] d;
      logic        e;
      do_reset(16'hFB5F, 8'hA5);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (switching_enable !== 1'b1 && n < 100);
      // capture edge plus table init, seen one edge later
      check("switch delay", 32'(TIC + 2), 32'(n));
      check_opts(16'hFB5F, 8'hA5);
      rd_chk("state", 12'h00C, 32'h0000_0037);
      // aging 300 s, flow control after 96 frames
      rd_chk("sys cfg", 12'h010, {16'h0060, 16'h012C});
      rd_chk("access pool", 12'h014, {16'h0030, 16'h0060});
      rd_chk("uplink pool", 12'h018, {16'h00C0, 16'h0180});
      rd_chk("cpu port", 12'h01C, {4'h8, 12'h000, 8'h30, 8'h60});
      rd_chk("frame size", 12'h020, {16'h05F2, 16'h0040});
      rd_chk("flags", 12'h024, 32'h0020_BF45);
      apb(1'b1, 12'h010, 32'h0000_0000, d, e);
      rd_chk("sys cfg kept", 12'h010, {16'h0060, 16'h012C});
      apb(1'b0, 12'h100, 32'h0000_0000, d, e);
      check("unmapped error", 32'h0000_0001, {31'h0, e});
      wiggle <= 1'b1;
      repeat (4) @(posedge pclk);
      check_opts(16'hFB5F, 8'hA5);
      wiggle <= 1'b0;
   endtask

   // idle ports sleep and wake; stuck busy gives one late pulse
   task automatic sc_power_timeout();
      int n;
      int f;
      @(posedge pclk);
      port_activity <= 9'h000;
      repeat (IDC - 1) @(posedge pclk);
      check("awake early", 32'h0000_0000, {23'h0, port_low_power});
      repeat (3) @(posedge pclk);
      check("asleep", 32'h0000_01FF, {23'h0, port_low_power});
      // enable low freezes the sleep state even though activity returns
      clk_en        <= 1'b0;
      port_activity <= 9'h101;
      repeat (2) @(posedge pclk);
      check("frozen", 32'h0000_01FF, {23'h0, port_low_power});
      clk_en <= 1'b1;
      repeat (2) @(posedge pclk);
      check("woken", 32'h0000_00FE, {23'h0, port_low_power});
      port_activity <= 9'h1FF;
      fsm_busy <= 1'b1;
      repeat (TOC - 5) @(posedge pclk);
      fsm_busy <= 1'b0;
      @(posedge pclk);
      fsm_busy <= 1'b1;
      n = 0;
      f = 0;
      for (int i = 1; i <= TOC + 8; i++) begin
         @(posedge pclk);
         if (timeout_reset_req === 1'b1) begin
            n++;
            f = i;
         end
      end
      fsm_busy <= 1'b0;
      check("timeout pulses", 32'h0000_0001, 32'(n));
      check("timeout restarted", 32'(TOC + 1), 32'(f));
   endtask

   // lightly managed: host waits, overrides, then sets init-complete
   task automatic sc_managed();
      logic [31:0] d;
      logic        e;
      do_reset(16'hE126, 8'h3C);
      // too early: tables still initialising, must be ignored
      apb(1'b1, 12'h000, 32'h0000_0010, d, e);
      check_opts(16'hE126, 8'h3C);
      repeat (20) @(posedge pclk);
      check("managed idle", 32'h0000_0000, {31'h0, switching_enable});
      rd_chk("state wait", 12'h00C, 32'h0000_001E);
      apb(1'b1, 12'h010, {16'h0030, 16'h0078}, d, e);
      rd_chk("sys cfg override", 12'h010, {16'h0030, 16'h0078});
      apb(1'b1, 12'h000, 32'h0000_0010, d, e);
      check("not yet switching", 32'h0000_0000, {31'h0, switching_enable});
      repeat (2) @(posedge pclk);
      check("switching", 32'h0000_0001, {31'h0, switching_enable});
      apb(1'b1, 12'h000, 32'h0000_0000, d, e);
      rd_chk("init sticky", 12'h000, 32'h0000_0010);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      sc_unmanaged();
      sc_power_timeout();
      sc_managed();
      tally_and_finish();
   end
endmodule
